/* File: verilog/dcc_pkg.sv */
package dcc_pkg;

    // Register map
    localparam logic [11:0] CTL_OFFSET = 12'h000;
    localparam logic [31:0] CTL_RESET = 32'h00000000;
    // Reserved bits 31:29 and 15:13 stay zero
    localparam logic [31:0] CTL_WMASK = 32'h1FFF1FFF;

    // Field positions for channel 0; channel 1 sits one stride higher
    localparam int CH_STRIDE = 16;
    localparam int POS_CHAN_ON = 0;
    localparam int POS_BUF_OFF = 1;
    localparam int POS_TRIG_ON = 2;
    localparam int POS_TRIG_SRC = 3;
    localparam int POS_WAVE_SEL = 6;
    localparam int POS_WAVE_WIDTH = 8;
    localparam int POS_DMA_ON = 12;

    // Trigger source codes
    localparam logic [2:0] SRC_TIMER5 = 3'h0;
    localparam logic [2:0] SRC_TIMER2 = 3'h1;
    localparam logic [2:0] SRC_TIMER6 = 3'h2;
    localparam logic [2:0] SRC_TIMER4 = 3'h3;
    localparam logic [2:0] SRC_TIMER1 = 3'h4;
    localparam logic [2:0] SRC_TIMER3 = 3'h5;
    localparam logic [2:0] SRC_EXT_LINE = 3'h6;
    localparam logic [2:0] SRC_SOFTWARE = 3'h7;

    // Widest wave and the code from which it saturates
    localparam logic [3:0] WIDTH_MAX = 4'hC;
    localparam logic [3:0] WIDTH_SAT_CODE = 4'hB;

    typedef enum logic [1:0] {
        DCC_WAVE_NONE = 2'b00,
        DCC_WAVE_NOISE = 2'b01,
        DCC_WAVE_TRI = 2'b10
    } dcc_wave_t;

    // Wave width n from the four-bit code
    function automatic logic [3:0] width_of(input logic [3:0] code);
        if (code >= WIDTH_SAT_CODE) begin
            return WIDTH_MAX;
        end
        return code + 4'h1;
    endfunction

    // Low n bits set; equals (2<<(n-1))-1 as well
    function automatic logic [11:0] ones_of(input logic [3:0] code);
        logic [12:0] full;
        full = 13'h0001 << width_of(code);
        return 12'(full - 13'h0001);
    endfunction

endpackage

/* File: verilog/dcc_chan.sv */
`timescale 1ns/10ps

module dcc_chan (
    // Clock and reset
    input wire logic clk_i,
    input wire logic reset_i,
    // Channel fields
    input wire logic dma_on_i,
    input wire logic [3:0] wave_width_i,
    input wire logic [1:0] wave_select_i,
    input wire logic [2:0] trigger_source_i,
    input wire logic trigger_on_i,
    input wire logic buffer_off_i,
    input wire logic channel_on_i,
    // Events: rise of timers 1..6 in bits 0..5, line 9 in bit 6
    input wire logic [6:0] hw_rise_i,
    input wire logic sw_trig_i,
    // Registered results
    output logic channel_on_o,
    output logic buffer_off_o,
    output dcc_pkg::dcc_wave_t wave_mode_o,
    output logic [11:0] noise_mask_o,
    output logic [11:0] tri_max_o,
    output logic transfer_o,
    output logic dma_req_o
);

    logic event_hit;
    logic hw_source;
    dcc_pkg::dcc_wave_t next_wave;

    always_comb begin
        case (trigger_source_i)
            dcc_pkg::SRC_TIMER5: event_hit = hw_rise_i[4];
            dcc_pkg::SRC_TIMER2: event_hit = hw_rise_i[1];
            dcc_pkg::SRC_TIMER6: event_hit = hw_rise_i[5];
            dcc_pkg::SRC_TIMER4: event_hit = hw_rise_i[3];
            dcc_pkg::SRC_TIMER1: event_hit = hw_rise_i[0];
            dcc_pkg::SRC_TIMER3: event_hit = hw_rise_i[2];
            dcc_pkg::SRC_EXT_LINE: event_hit = hw_rise_i[6];
            default: event_hit = sw_trig_i;
        endcase
    end

    assign hw_source = trigger_source_i != dcc_pkg::SRC_SOFTWARE;

    always_comb begin
        if (!trigger_on_i) begin
            next_wave = dcc_pkg::DCC_WAVE_NONE;
        end else if (wave_select_i[1]) begin
            next_wave = dcc_pkg::DCC_WAVE_TRI;
        end else if (wave_select_i[0]) begin
            next_wave = dcc_pkg::DCC_WAVE_NOISE;
        end else begin
            next_wave = dcc_pkg::DCC_WAVE_NONE;
        end
    end

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            channel_on_o <= 1'b0;
            buffer_off_o <= 1'b0;
            wave_mode_o <= dcc_pkg::DCC_WAVE_NONE;
            noise_mask_o <= 12'h000;
            tri_max_o <= 12'h000;
        end else begin
            channel_on_o <= channel_on_i;
            buffer_off_o <= buffer_off_i;
            wave_mode_o <= next_wave;
            noise_mask_o <= dcc_pkg::ones_of(wave_width_i);
            tri_max_o <= dcc_pkg::ones_of(wave_width_i);
        end
    end

    // Untriggered channels load continuously; triggered ones on the event
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            transfer_o <= 1'b0;
            dma_req_o <= 1'b0;
        end else begin
            transfer_o <= !trigger_on_i || event_hit;
            dma_req_o <= trigger_on_i && dma_on_i && hw_source
                         && event_hit;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    default clocking @(posedge clk_i); endclocking
    default disable iff (reset_i);

    a_wave_gated: assert property (!trigger_on_i |=>
        wave_mode_o == dcc_pkg::DCC_WAVE_NONE)
        else $error("wave active without trigger enable");
    a_tri_decode: assert property (trigger_on_i && wave_select_i[1] |=>
        wave_mode_o == dcc_pkg::DCC_WAVE_TRI)
        else $error("triangle mode not decoded");
    a_width_saturates: assert property (wave_width_i >= 4'hB |=>
        noise_mask_o == 12'hFFF && tri_max_o == 12'hFFF)
        else $error("width above 11 not saturated to 12");
    a_width_one: assert property (wave_width_i == 4'h0 |=>
        noise_mask_o == 12'h001 && tri_max_o == 12'h001)
        else $error("width code 0 not one bit");
    a_width_six: assert property (wave_width_i == 4'h5 |=>
        tri_max_o == 12'h03F)
        else $error("width code 5 amplitude wrong");
    a_sw_no_dma: assert property (trigger_source_i == 3'h7 |=>
        !dma_req_o)
        else $error("dma request on software trigger");
    a_hw_dma: assert property (trigger_on_i && dma_on_i
        && trigger_source_i == 3'h4 && hw_rise_i[0] |=> dma_req_o && transfer_o)
        else $error("timer 1 event did not raise dma");
    a_src_ignored: assert property (!trigger_on_i |=> transfer_o
        && !dma_req_o)
        else $error("disabled trigger not ignored");
    a_ext_line: assert property (trigger_on_i
        && trigger_source_i == 3'h6 && !hw_rise_i[6] |=> !transfer_o)
        else $error("transfer without line 9 event");

    c_dma_req: cover property (dma_req_o);
    c_tri_mode: cover property (wave_mode_o == dcc_pkg::DCC_WAVE_TRI);
    c_noise_mode: cover property (wave_mode_o == dcc_pkg::DCC_WAVE_NOISE
        && noise_mask_o == 12'h0FF);

endmodule

/* File: verilog/dcc_ctrl.sv */
`timescale 1ns/10ps

// Overview of operation
// - Control register clears to all zeros on reset.
// - Bits 28 and 12 enable DMA mode for channels one and zero.
// - Width code selects width code plus one; codes 11 and up give 12.
// - Noise mode passes only the low n shift register bits.
// - Triangle amplitude limited to (2<<(n-1))-1.
// - Wave mode applies only while the channel trigger enable is set.
// - Source ignored unless trigger enabled; selected event starts transfer.
// - Bit 18 enables channel one triggered operation.
// - Bit 17 set turns channel one output buffer off.
// - DMA request on each hardware trigger event, never on software.

module dcc_ctrl (
    // Clock and reset
    input wire logic clk_i,
    input wire logic reset_i,
    // APB slave
    input wire logic [11:0] paddr_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // Trigger sources: timers 1..6 in bits 0..5
    input wire logic [5:0] timer_trigger_output_i,
    input wire logic external_interrupt_line_i,
    input wire logic [1:0] sw_trig_i,
    // Per-channel results, index is the channel
    output logic [1:0] channel_on_o,
    output logic [1:0] buffer_off_o,
    output logic [1:0][1:0] wave_mode_o,
    output logic [1:0][11:0] noise_mask_o,
    output logic [1:0][11:0] tri_max_o,
    output logic [1:0] transfer_o,
    output logic [1:0] dma_req_o
);

    logic [31:0] ctl;
    logic [6:0] src_prev;
    logic [6:0] hw_rise;
    logic hit;
    logic access;
    logic commit;

    ////////////////////////////////////////////////////////////////////////
    // APB slave: one wait state so that every answer leaves a flip-flop
    assign hit = paddr_i[11:2] == dcc_pkg::CTL_OFFSET[11:2];
    assign access = psel_i && penable_i && !pready_o;
    assign commit = psel_i && penable_i && pready_o;

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            pready_o <= 1'b0;
        end else begin
            pready_o <= access;
        end
    end

    // Unmapped addresses answer with an error and read as zero
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            prdata_o <= 32'h00000000;
            pslverr_o <= 1'b0;
        end else if (access) begin
            prdata_o <= (hit && !pwrite_i) ? ctl : 32'h00000000;
            pslverr_o <= !hit;
        end else begin
            prdata_o <= 32'h00000000;
            pslverr_o <= 1'b0;
        end
    end

    // Byte lanes are not decoded: every write is a whole word
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            ctl <= dcc_pkg::CTL_RESET;
        end else if (commit && pwrite_i && hit) begin
            ctl <= pwdata_i & dcc_pkg::CTL_WMASK;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Hardware triggers act on their rising edge
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            src_prev <= 7'h00;
        end else begin
            src_prev <= {external_interrupt_line_i, timer_trigger_output_i};
        end
    end

    assign hw_rise = {external_interrupt_line_i, timer_trigger_output_i}
                     & ~src_prev;

    ////////////////////////////////////////////////////////////////////////
    // Channel 1 fields sit one stride above channel 0
    for (genvar ch = 0; ch < 2; ch++) begin : g_chan
        localparam int B = ch * dcc_pkg::CH_STRIDE;
        dcc_pkg::dcc_wave_t mode;

        dcc_chan u_chan (
            .clk_i(clk_i),
            .reset_i(reset_i),
            .dma_on_i(ctl[B + dcc_pkg::POS_DMA_ON]),
            .wave_width_i(ctl[B + dcc_pkg::POS_WAVE_WIDTH +: 4]),
            .wave_select_i(ctl[B + dcc_pkg::POS_WAVE_SEL +: 2]),
            .trigger_source_i(ctl[B + dcc_pkg::POS_TRIG_SRC +: 3]),
            .trigger_on_i(ctl[B + dcc_pkg::POS_TRIG_ON]),
            .buffer_off_i(ctl[B + dcc_pkg::POS_BUF_OFF]),
            .channel_on_i(ctl[B + dcc_pkg::POS_CHAN_ON]),
            .hw_rise_i(hw_rise),
            .sw_trig_i(sw_trig_i[ch]),
            .channel_on_o(channel_on_o[ch]),
            .buffer_off_o(buffer_off_o[ch]),
            .wave_mode_o(mode),
            .noise_mask_o(noise_mask_o[ch]),
            .tri_max_o(tri_max_o[ch]),
            .transfer_o(transfer_o[ch]),
            .dma_req_o(dma_req_o[ch])
        );

        assign wave_mode_o[ch] = mode;
    end

    ////////////////////////////////////////////////////////////////////////
    default clocking @(posedge clk_i); endclocking
    default disable iff (reset_i);

    a_ready_wait: assert property (psel_i && penable_i && !pready_o |=>
        pready_o)
        else $error("pready not raised after one wait state");
    a_ready_pulse: assert property (pready_o |=> !pready_o)
        else $error("pready held longer than one cycle");
    a_write_lands: assert property (commit && pwrite_i && hit |=>
        ctl == ($past(pwdata_i) & 32'h1FFF1FFF))
        else $error("write not stored with reserved bits cleared");
    a_read_back: assert property (access && !pwrite_i && hit |=>
        prdata_o == $past(ctl) && !pslverr_o)
        else $error("read data differs from control register");
    a_unmapped: assert property (access && !hit |=> pslverr_o
        && prdata_o == 32'h00000000)
        else $error("unmapped access not refused");
    a_buf_bit: assert property (ctl[17] |=> buffer_off_o[1])
        else $error("bit 17 did not turn buffer off");
    a_mirror: assert property (ctl[2] && ctl[7] |=>
        wave_mode_o[0] == 2'b10)
        else $error("channel 0 triangle not mirrored");
    a_trig_bit: assert property (!ctl[18] |=> transfer_o[1])
        else $error("channel 1 not continuous with trigger off");

    // Bus side: refused writes leave the register alone
    a_write_drop: assert property (commit && !hit |=> $stable(ctl))
        else $error("write to unmapped address changed control");
    a_err_pulse: assert property (pslverr_o |-> pready_o)
        else $error("error flag without ready");
    a_data_idle: assert property (!pready_o |-> prdata_o == 32'h00000000)
        else $error("read data not zero outside answer");

    // Static fields of both channels
    a_chan_one: assert property (ctl[16] |=> channel_on_o[1])
        else $error("channel 1 enable not copied");
    a_chan_zero: assert property (!ctl[0] |=> !channel_on_o[0])
        else $error("channel 0 enable not cleared");
    a_buf_on: assert property (!ctl[17] |=> !buffer_off_o[1])
        else $error("channel 1 buffer off with bit 17 clear");
    a_buf_zero: assert property (ctl[1] |=> buffer_off_o[0])
        else $error("bit 1 did not turn buffer off");
    a_dma_off_one: assert property (!ctl[28] |=> !dma_req_o[1])
        else $error("channel 1 dma request with dma off");
    a_dma_off_zero: assert property (!ctl[12] |=> !dma_req_o[0])
        else $error("channel 0 dma request with dma off");
    a_width_mirror: assert property (ctl[11:8] == 4'h7 |=>
        noise_mask_o[0] == 12'h0FF)
        else $error("channel 0 width code 7 mask wrong");
    a_width_top: assert property (ctl[27:24] >= 4'hB |=>
        tri_max_o[1] == 12'hFFF)
        else $error("channel 1 width not saturated");
    a_noise_one: assert property (ctl[18] && ctl[23:22] == 2'h1 |=>
        wave_mode_o[1] == 2'h1)
        else $error("channel 1 noise mode not decoded");
    a_none_one: assert property (ctl[23:22] == 2'h0 |=>
        wave_mode_o[1] == 2'h0)
        else $error("channel 1 wave active with select 0");
    a_gate_zero: assert property (!ctl[2] |=> wave_mode_o[0] == 2'h0)
        else $error("channel 0 wave active without trigger");

    // Trigger routing; a hardware level held high gives only one event
    a_timer5_pick: assert property (ctl[2] && ctl[5:3] == 3'h0
        && hw_rise[4] |=> transfer_o[0])
        else $error("timer 5 event did not start transfer");
    a_timer5_only: assert property (ctl[2] && ctl[5:3] == 3'h0
        && !hw_rise[4] |=> !transfer_o[0])
        else $error("transfer without timer 5 event");
    a_timer2_one: assert property (ctl[18] && ctl[21:19] == 3'h1
        && hw_rise[1] |=> transfer_o[1])
        else $error("timer 2 event did not start channel 1");
    a_line_dma: assert property (ctl[18] && ctl[28]
        && ctl[21:19] == 3'h6 && hw_rise[6] |=> dma_req_o[1] && transfer_o[1])
        else $error("line 9 event did not raise dma");
    a_sw_one: assert property (ctl[18] && ctl[21:19] == 3'h7
        && sw_trig_i[1] |=> transfer_o[1] && !dma_req_o[1])
        else $error("software trigger handled wrongly");
    a_timer3_dma: assert property (ctl[2] && ctl[12]
        && ctl[5:3] == 3'h5 && hw_rise[2] |=> dma_req_o[0])
        else $error("timer 3 event did not raise dma");
    a_hold_no_rise: assert property (ctl[2] && ctl[5:3] == 3'h4
        && src_prev[0] |=> !transfer_o[0])
        else $error("held timer 1 level repeated the event");

    a_reset_clear: assert property (@(posedge clk_i) $fell(reset_i) |->
        ctl == 32'h00000000 && dma_req_o == 2'b00)
        else $error("control not zero after reset");

    c_write: cover property (commit && pwrite_i && hit);
    c_read: cover property (commit && !pwrite_i && hit);

endmodule

/* File: sim/dac_channel_control_register_tb_top.sv */
`timescale 1ns/10ps

module dac_channel_control_register_tb_top;
    typedef struct {int at; logic [31:0] ctl; logic [1:0] tr; logic [1:0] dma;} dcc_ev_t;
    typedef struct {logic rd; logic [31:0] data; logic err;} dcc_rsp_t;
    logic clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic [11:0] paddr_i = 12'h000;
    logic psel_i = 1'b0;
    logic penable_i = 1'b0;
    logic pwrite_i = 1'b0;
    logic [31:0] pwdata_i = 32'h00000000;
    logic [31:0] prdata_o;
    logic pready_o;
    logic pslverr_o;
    logic [5:0] timer_trigger_output_i = 6'h00;
    logic external_interrupt_line_i = 1'b0;
    logic [1:0] sw_trig_i = 2'h0;
    logic [1:0] channel_on_o;
    logic [1:0] buffer_off_o;
    logic [1:0] transfer_o;
    logic [1:0] dma_req_o;
    logic [1:0][1:0] wave_mode_o;
    logic [1:0][11:0] noise_mask_o;
    logic [1:0][11:0] tri_max_o;
    int fails = 0;
    int compares = 0;
    int cyc = 0;
    int seed = 93428;
    int tmap[6] = '{4, 1, 5, 3, 0, 2};
    logic [31:0] ctl = 32'h00000000;
    dcc_ev_t evq[$];
    dcc_rsp_t rspq[$];

    always #2 clk_i = ~clk_i;

    // Cycle count doubles as the hang guard
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            fails++;
            print_verdict();
        end
    end

    dcc_ctrl dut (
        .clk_i(clk_i), .reset_i(reset_i), .paddr_i(paddr_i),
        .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
        .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
        .pslverr_o(pslverr_o),
        .timer_trigger_output_i(timer_trigger_output_i),
        .external_interrupt_line_i(external_interrupt_line_i),
        .sw_trig_i(sw_trig_i), .channel_on_o(channel_on_o),
        .buffer_off_o(buffer_off_o), .wave_mode_o(wave_mode_o),
        .noise_mask_o(noise_mask_o), .tri_max_o(tri_max_o),
        .transfer_o(transfer_o), .dma_req_o(dma_req_o)
    );

    ////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            fails++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic print_verdict();
        fails += evq.size() + rspq.size();
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // Outputs land one cycle after the driving edge
    task automatic note(input logic [1:0] tr, input logic [1:0] dm);
        dcc_ev_t e;
        e = '{cyc + 2, ctl, tr, dm};
        evq.push_back(e);
    endtask

    task automatic apb(input logic [11:0] a, input logic wr,
                       input logic [31:0] d);
        dcc_rsp_t r;
        r = '{!wr, (a == 12'h000) ? ctl : 32'h0, a != 12'h000};
        rspq.push_back(r);
        @(posedge clk_i);
        psel_i <= 1'b1;
        paddr_i <= a;
        pwrite_i <= wr;
        pwdata_i <= d;
        @(posedge clk_i);
        penable_i <= 1'b1;
        do @(posedge clk_i); while (pready_o !== 1'b1);
        psel_i <= 1'b0;
        penable_i <= 1'b0;
        if (wr && a == 12'h000)
            ctl = d & 32'h1FFF1FFF;
        if (wr)
            note(2'b00, 2'b00);
    endtask

    // Holds the event two cycles: a level repeats only software pulses
    task automatic fire(input logic [8:0] ev, input logic [1:0] tr,
                        input logic [1:0] dm, input logic [1:0] tr2);
        @(posedge clk_i);
        timer_trigger_output_i <= ev[5:0];
        external_interrupt_line_i <= ev[6];
        sw_trig_i <= ev[8:7];
        note(tr, dm);
        @(posedge clk_i);
        note(tr2, 2'b00);
        @(posedge clk_i);
        timer_trigger_output_i <= 6'h00;
        external_interrupt_line_i <= 1'b0;
        sw_trig_i <= 2'h0;
        note(2'b00, 2'b00);
    endtask

    task automatic do_reset();
        // Pending notes expect the old setup, so let them drain first
        while (evq.size() > 0)
            @(posedge clk_i);
        reset_i <= 1'b1;
        repeat (5) @(posedge clk_i);
        reset_i <= 1'b0;
        ctl = 32'h00000000;
        note(2'b00, 2'b00);
    endtask

    ////////////////////////////////////////////////////////////////////////
    always @(negedge clk_i) begin : mon
        dcc_rsp_t r;
        dcc_ev_t e;
        logic [15:0] f;
        logic [11:0] m;
        logic [1:0] wm;
        if (pready_o === 1'b1) begin
            if (rspq.size() == 0) begin
                check(32'h1, 32'h0);
            end else begin
                r = rspq.pop_front();
                check(32'(pslverr_o), 32'(r.err));
                if (r.rd)
                    check(prdata_o, r.data);
            end
        end
        if (evq.size() > 0 && evq[0].at == cyc) begin
            e = evq.pop_front();
            for (int c = 0; c < 2; c++) begin
                f = e.ctl[16 * c +: 16];
                m = (f[11:8] >= 4'hB) ? 12'hFFF :
                    12'((13'h0002 << f[11:8]) - 13'h0001);
                wm = f[2] ? (f[7] ? 2'h2 : {1'b0, f[6]}) : 2'h0;
                check(32'({channel_on_o[c], buffer_off_o[c], wave_mode_o[c]}),
                      32'({f[0], f[1], wm}));
                check(32'({noise_mask_o[c], tri_max_o[c]}),
                      32'({m, m}));
                check(32'({transfer_o[c], dma_req_o[c]}),
                      32'({!f[2] | e.tr[c], e.dma[c]}));
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    initial begin
        logic [31:0] w;
        logic [8:0] ok;
        logic [8:0] bad;
        logic [1:0] oh;
        int k;
        do_reset();
        apb(12'h000, 1'b0, 32'h0);
        $display("reset test done");
        for (int i = 0; i < 16; i++) begin
            w = $random(seed) & 32'h1FFF1FFF;
            w[27:22] = {4'(i), 2'(i)};
            w[11:6] = {4'(15 - i), 2'(i >> 2)};
            w[18] = i[2];
            w[2] = i[0];
            apb(12'h000, 1'b1, w);
            apb(12'h000, 1'b0, 32'h0);
        end
        $display("field test done");
        // Unmapped places must neither store nor return data
        apb(12'h004, 1'b1, $random(seed));
        apb(12'h004, 1'b0, 32'h0);
        apb(12'hFFC, 1'b0, 32'h0);
        apb(12'h000, 1'b0, 32'h0);
        $display("unmapped test done");
        for (int ch = 0; ch < 2; ch++) begin
            for (int code = 0; code < 8; code++) begin
                oh = 2'b01 << ch;
                w = (32'h00001004 | (32'(code) << 3)) << (16 * ch);
                apb(12'h000, 1'b1, w);
                k = ($random(seed) & 32'h7FFF) % 6;
                if (code < 6 && k == tmap[code])
                    k = (k + 1) % 6;
                bad = (9'h001 << k) | ((code == 7) ? 9'h0 : 9'(oh) << 7);
                ok = (code < 6) ? 9'h001 << tmap[code] :
                     ((code == 6) ? 9'h040 : 9'(oh) << 7);
                fire(bad, 2'b00, 2'b00, 2'b00);
                fire(ok, oh, (code < 7) ? oh : 2'b00,
                     (code == 7) ? oh : 2'b00);
            end
        end
        $display("trigger test done");
        do_reset();
        apb(12'h000, 1'b0, 32'h0);
        $display("second reset test done");
        repeat (4) @(posedge clk_i);
        print_verdict();
    end
endmodule
